// ===== rtl/general_timer_module.sv
// Purpose: three timer blocks, each two 16-bit halves or one 32-bit timer
// Assumes: rtc_clk_in is a 32.768 kHz level synchronous to ref_clk
// Notes:   controls are plain ports, one slice per block
// Contract
// - three identical timer blocks, each configured independently.
// - each block has two 16-bit timer/counters, timer or event counter.
// - a block can join its halves into one 32-bit timer or rtc.
// - joined block modes: real-time clock, one-shot, periodic.
// - 16-bit one-shot and periodic may use an 8-bit prescaler.
// - each 16-bit half may capture input events or generate pwm.
// - pwm drives the ccp pin; software may invert the output.
// - counting and capture modes act on external timer input pins.
// - capture offers edge counting and edge time capture.
// - 32-bit rtc mode counts rising edges of the 32.768 kHz input.
// - with stall enabled, timed modes pause while cpu halt is set.
`timescale 1ns/1ps
module general_timer_module
   import gp_timer_pkg::*;
#(
   parameter int BLOCKS = NUM_BLOCKS
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        cpu_halt,
   input  wire logic                        rtc_clk_in,
   input  wire logic [BLOCKS-1:0]           joined,
   input  wire logic [BLOCKS*MODE_W-1:0]    mode_a,
   input  wire logic [BLOCKS*MODE_W-1:0]    mode_b,
   input  wire logic [BLOCKS-1:0]           enable_a,
   input  wire logic [BLOCKS-1:0]           enable_b,
   input  wire logic [BLOCKS*2-1:0]         edge_a,
   input  wire logic [BLOCKS*2-1:0]         edge_b,
   input  wire logic [BLOCKS*32-1:0]        load_value,
   input  wire logic [BLOCKS*32-1:0]        match_value,
   input  wire logic [BLOCKS*16-1:0]        prescale,
   input  wire logic [BLOCKS-1:0]           stall_en,
   input  wire logic [BLOCKS*2-1:0]         pwm_invert,
   input  wire logic [BLOCKS*2-1:0]         ccp_in,
   output logic [BLOCKS*32-1:0]             count,
   output logic [BLOCKS*32-1:0]             capture,
   output logic [BLOCKS*2-1:0]              timeout,
   output logic [BLOCKS*2-1:0]              capture_event,
   output logic [BLOCKS*2-1:0]              ccp_out,
   output logic [BLOCKS*2-1:0]              ccp_oe
);
   import gp_timer_pkg::*;

   logic rtc_prev;
   always_ff @(posedge ref_clk) begin
      if (!rst_n)
         rtc_prev <= 1'b0;
      else
         rtc_prev <= rtc_clk_in;
   end
   wire rtc_tick = rtc_clk_in && !rtc_prev;

   // ------------------------------------------------------------
   // per-block slices
   // ------------------------------------------------------------
   for (genvar b = 0; b < BLOCKS; b++) begin : g_blk
      timer_mode_t      m_a;
      timer_mode_t      m_b;
      logic [15:0]      cnt_a;
      logic [15:0]      cnt_b;
      logic [15:0]      cap_a;
      logic [15:0]      cap_b;
      logic             to_a;
      logic             to_b;
      logic [31:0]      cnt32;
      logic             run32;
      logic             to32;

      assign m_a = timer_mode_t'(mode_a[b*MODE_W +: MODE_W]);
      assign m_b = timer_mode_t'(mode_b[b*MODE_W +: MODE_W]);

      wire join_on = joined[b];
      wire half_a_en = enable_a[b] && !join_on;
      wire half_b_en = enable_b[b] && !join_on;

      timer_half u_a (
         .ref_clk       (ref_clk),
         .rst_n         (rst_n),
         .enable        (half_a_en),
         .mode          (m_a),
         .edge_sel      (edge_sel_t'(edge_a[b*2 +: 2])),
         .load_value    (load_value[b*32 +: 16]),
         .match_value   (match_value[b*32 +: 16]),
         .prescale      (prescale[b*16 +: 8]),
         .stall_en      (stall_en[b]),
         .cpu_halt      (cpu_halt),
         .pwm_invert    (pwm_invert[b*2]),
         .ccp_in        (ccp_in[b*2]),
         .count         (cnt_a),
         .capture       (cap_a),
         .timeout       (to_a),
         .capture_event (capture_event[b*2]),
         .ccp_out       (ccp_out[b*2]),
         .ccp_oe        (ccp_oe[b*2])
      );

      timer_half u_b (
         .ref_clk       (ref_clk),
         .rst_n         (rst_n),
         .enable        (half_b_en),
         .mode          (m_b),
         .edge_sel      (edge_sel_t'(edge_b[b*2 +: 2])),
         .load_value    (load_value[b*32+16 +: 16]),
         .match_value   (match_value[b*32+16 +: 16]),
         .prescale      (prescale[b*16+8 +: 8]),
         .stall_en      (stall_en[b]),
         .cpu_halt      (cpu_halt),
         .pwm_invert    (pwm_invert[b*2+1]),
         .ccp_in        (ccp_in[b*2+1]),
         .count         (cnt_b),
         .capture       (cap_b),
         .timeout       (to_b),
         .capture_event (capture_event[b*2+1]),
         .ccp_out       (ccp_out[b*2+1]),
         .ccp_oe        (ccp_oe[b*2+1])
      );

      // joined 32-bit timer: one-shot, periodic down, rtc counts up
      wire j_en    = join_on && enable_a[b];
      wire j_rtc   = (m_a == MODE_RTC);
      wire j_timed = (m_a == MODE_ONE_SHOT) || (m_a == MODE_PERIODIC);
      wire j_stall = stall_en[b] && cpu_halt && j_timed;
      wire j_tick  = j_en && (j_rtc ? rtc_tick
                            : (j_timed && run32 && !j_stall));
      wire j_zero  = (cnt32 == 32'h00000000);
      wire j_rtc_match = j_rtc && (cnt32 == load_value[b*32 +: 32]);
      wire [31:0] next_cnt32 =
         j_rtc ? cnt32 + 32'h00000001
               : (j_zero ? load_value[b*32 +: 32]
                         : cnt32 - 32'h00000001);

      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            cnt32 <= FULL_RESET;
            run32 <= 1'b0;
            to32  <= 1'b0;
         end else if (!j_en) begin
            cnt32 <= j_rtc ? 32'h00000000 : load_value[b*32 +: 32];
            run32 <= 1'b1;
            to32  <= 1'b0;
         end else begin
            to32 <= j_tick && (j_rtc ? j_rtc_match : j_zero);
            if (j_tick) begin
               cnt32 <= next_cnt32;
               if (j_zero && !j_rtc && m_a == MODE_ONE_SHOT)
                  run32 <= 1'b0;
            end
         end
      end

      assign count[b*32 +: 32]   = join_on ? cnt32 : {cnt_b, cnt_a};
      assign capture[b*32 +: 32] = {cap_b, cap_a};
      assign timeout[b*2]        = join_on ? to32 : to_a;
      assign timeout[b*2+1]      = join_on ? 1'b0 : to_b;
   end

endmodule // general_timer_module

// ===== rtl/gp_timer_pkg.sv
// Purpose: shared constants and types of the general timer module
// Assumes: one 40 MHz clock, synchronous active-low reset
// Notes:   no register bus; all controls are plain ports
package gp_timer_pkg;

   localparam int NUM_BLOCKS   = 3;
   localparam int HALF_WIDTH   = 16;
   localparam int FULL_WIDTH   = 32;
   localparam int PRESCALE_W   = 8;
   localparam int MODE_W       = 3;
   localparam logic [15:0] HALF_RESET  = 16'hffff;
   localparam logic [31:0] FULL_RESET  = 32'hffffffff;
   localparam logic [7:0]  PRE_RESET   = 8'h00;

   // half modes (16-bit) and joined modes (32-bit) share one encoding
   typedef enum logic [2:0] {
      MODE_OFF      = 3'h0,
      MODE_ONE_SHOT = 3'h1,
      MODE_PERIODIC = 3'h2,
      MODE_EDGE_CNT = 3'h3,
      MODE_EDGE_TIM = 3'h4,
      MODE_PWM      = 3'h5,
      MODE_RTC      = 3'h6
   } timer_mode_t;

   // edge selection of an input pin
   typedef enum logic [1:0] {
      EDGE_RISE = 2'h0,
      EDGE_FALL = 2'h1,
      EDGE_BOTH = 2'h2
   } edge_sel_t;

endpackage

// ===== rtl/timer_half.sv
// Purpose: one 16-bit timer/counter half with prescaler, capture and pwm
// Assumes: pin inputs synchronous to ref_clk
// Notes:   counts down from load value; pwm high while count > match
`timescale 1ns/1ps
module timer_half
   import gp_timer_pkg::*;
#(
   parameter int WIDTH = HALF_WIDTH,
   parameter int PW    = PRESCALE_W
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              enable,
   input  wire gp_timer_pkg::timer_mode_t mode,
   input  wire gp_timer_pkg::edge_sel_t   edge_sel,
   input  wire logic [WIDTH-1:0]  load_value,
   input  wire logic [WIDTH-1:0]  match_value,
   input  wire logic [PW-1:0]     prescale,
   input  wire logic              stall_en,
   input  wire logic              cpu_halt,
   input  wire logic              pwm_invert,
   input  wire logic              ccp_in,
   output logic [WIDTH-1:0]       count,
   output logic [WIDTH-1:0]       capture,
   output logic                   timeout,
   output logic                   capture_event,
   output logic                   ccp_out,
   output logic                   ccp_oe
);
   import gp_timer_pkg::*;

   logic [PW-1:0] pre_count;
   logic          in_prev;
   logic          running;

   wire timed      = (mode == MODE_ONE_SHOT) || (mode == MODE_PERIODIC);
   wire rise       = ccp_in && !in_prev;
   wire fall       = !ccp_in && in_prev;
   wire edge_hit   = (edge_sel == EDGE_RISE) ? rise :
                     (edge_sel == EDGE_FALL) ? fall : (rise || fall);
   wire stalled    = stall_en && cpu_halt && timed;
   wire pre_done   = !timed || (pre_count == '0);
   wire tick_free  = enable && running && !stalled && pre_done;
   wire tick       = (mode == MODE_EDGE_CNT) ? (enable && edge_hit)
                   : tick_free;
   wire at_zero    = (count == '0);
   wire reload     = tick && at_zero;
   wire [WIDTH-1:0] next_count = reload ? load_value
                               : (count - {{(WIDTH-1){1'b0}}, 1'b1});
   wire next_pwm   = (count > match_value) ^ pwm_invert;

   // ------------------------------------------------------------
   // prescaler and counter
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pre_count <= PRE_RESET;
      end else if (!enable) begin
         pre_count <= prescale;
      end else if (!stalled) begin
         // a stall at the end of a prescale run must not swallow its tick
         pre_count <= pre_done ? prescale
                    : pre_count - {{(PW-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count   <= HALF_RESET[WIDTH-1:0];
         running <= 1'b0;
      end else if (!enable) begin
         count   <= load_value;
         running <= 1'b1;
      end else if (tick) begin
         count   <= next_count;
         // one-shot halts at time-out, periodic reloads
         if (reload && mode == MODE_ONE_SHOT)
            running <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         in_prev       <= 1'b0;
         capture       <= '0;
         capture_event <= 1'b0;
         timeout       <= 1'b0;
         ccp_out       <= 1'b0;
      end else begin
         in_prev       <= ccp_in;
         timeout       <= reload && timed;
         capture_event <= enable && edge_hit &&
                          (mode == MODE_EDGE_TIM || mode == MODE_EDGE_CNT);
         if (enable && edge_hit && mode == MODE_EDGE_TIM)
            capture <= count;
         ccp_out <= (enable && mode == MODE_PWM) ? next_pwm : 1'b0;
      end
   end

   assign ccp_oe = enable && (mode == MODE_PWM);

endmodule // timer_half

// ===== sim/general_timer_module_checker.sv
// Purpose: port assertions on block 0 of the timer module
// Assumes: one clock, synchronous active-low reset
// Notes:   of the other halves the bench judges only half 3 and the oe of half 1
`timescale 1ns/1ps
module general_timer_module_checker #(
   parameter int B = 3
) (
   input wire logic          ref_clk,
   input wire logic          rst_n,
   input wire logic          cpu_halt,
   input wire logic [B-1:0]  joined,
   input wire logic [B-1:0]  enable_a,
   input wire logic [B-1:0]  stall_en,
   input wire logic [3*B-1:0] mode_a,
   input wire logic [3*B-1:0] mode_b,
   input wire logic [2*B-1:0] edge_a,
   input wire logic [32*B-1:0] load_value,
   input wire logic [16*B-1:0] prescale,
   input wire logic [2*B-1:0] ccp_in,
   input wire logic [32*B-1:0] count,
   input wire logic [2*B-1:0] timeout,
   input wire logic [2*B-1:0] capture_event,
   input wire logic [2*B-1:0] ccp_out,
   input wire logic [2*B-1:0] ccp_oe
);
   wire logic       solo = !joined[0];
   wire logic       on = solo && enable_a[0];
   wire logic [2:0] ma = mode_a[2:0];
   wire logic [15:0] ld = load_value[15:0];
   // ---
   // properties
   // ---
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_PWM_OE: assert property (on && ma == 3'h5 |-> ccp_oe[0])
      else $error("pwm enable low");
   AST_PWM_IDLE: assert property (solo && ma == 3'h0 && $past(ma) == 3'h0 |-> !ccp_out[0])
      else $error("pwm out outside pwm");
   AST_TO_PULSE: assert property (timeout[0] |=> !timeout[0])
      else $error("timeout longer than one cycle");
   AST_PERIOD: assert property (on && ma == 3'h2 && timeout[0] && (ld == 16'h3 && prescale[7:0] == 8'h0 || ld == 16'h1 && prescale[7:0] == 8'h1) |=> !timeout[0] [*3] ##1 (timeout[0] || !enable_a[0]))
      else $error("period wrong");
   AST_STALL: assert property (on && stall_en[0] && cpu_halt && ma == 3'h2 |=> $stable(count[15:0]))
      else $error("count moved in stall");
   AST_ONESHOT: assert property (on && ma == 3'h1 && timeout[0] |=> (count[15:0] == ld && !timeout[0]) [*4])
      else $error("one-shot restarted");
   AST_CAP_EV: assert property (on && ma == 3'h4 && edge_a[1:0] == 2'h0 && $rose(ccp_in[0]) |-> ##[1:2] capture_event[0])
      else $error("edge not captured");
   AST_JOIN_B: assert property (joined[0] && mode_b[2:0] == 3'h5 |-> !ccp_oe[1])
      else $error("joined half drives pin");
endmodule // general_timer_module_checker
bind general_timer_module general_timer_module_checker #(.B(BLOCKS)) chk_i (
   .ref_clk, .rst_n, .cpu_halt, .joined, .enable_a, .stall_en, .mode_a,
   .mode_b, .edge_a, .load_value, .prescale, .ccp_in, .count, .timeout,
   .capture_event, .ccp_out, .ccp_oe);

// ===== sim/pin_wave_source.sv
// Purpose: square wave from an outside event source or rtc crystal
// Assumes: bench clock
// Notes:   rests low while run is low
`timescale 1ns/1ps
module pin_wave_source (
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic [7:0] half_period,
   output logic            wave
);
   int cnt = 0;
   initial wave = 1'b0;
   always @(posedge ref_clk) begin
      #1;
      if (!run) begin
         cnt = 0;
         wave = 1'b0;
      end else if (cnt == half_period) begin
         cnt = 0;
         wave = ~wave;
      end else begin
         cnt++;
      end
   end
endmodule // pin_wave_source

// ===== sim/general_timer_module_tb_top.sv
// Purpose: self-checking bench of the general timer module
// Assumes: 40 MHz clock, inputs driven 1 ns after the edge
// Notes:   pin 0 comes from a wave source unless ccp_oe[0] loops ccp_out[0] back; the rtc input from a wave source
`timescale 1ns/1ps
module general_timer_module_tb_top;
   import gp_timer_pkg::*;
   logic ref_clk = 0, rst_n = 0, cpu_halt = 0, src0, rtc;
   logic run0 = 0, run_rtc = 0;
   logic [2:0] joined = 0, enable_a = 0, enable_b = 0, stall_en = 0;
   logic [8:0] mode_a = 0, mode_b = 0;
   logic [5:0] edge_a = 0, edge_b = 0, pwm_invert = 0, ccp_in;
   logic [5:0] timeout, capture_event, ccp_out, ccp_oe;
   logic [95:0] load_value = 0, match_value = 0, count, capture;
   logic [47:0] prescale = 0;
   int failures = 0, n_compared = 0, cycles = 0;
   assign ccp_in = {5'h00, ccp_oe[0] ? ccp_out[0] : src0};
   general_timer_module general_timer_module_i (
      .ref_clk, .rst_n, .cpu_halt, .rtc_clk_in(rtc), .joined, .mode_a,
      .mode_b, .enable_a, .enable_b, .edge_a, .edge_b, .load_value,
      .match_value, .prescale, .stall_en, .pwm_invert, .ccp_in, .count,
      .capture, .timeout, .capture_event, .ccp_out, .ccp_oe);
   pin_wave_source pin_wave_source_i (.ref_clk, .run(run0),
      .half_period(8'h03), .wave(src0));
   pin_wave_source pin_wave_source_rtc_i (.ref_clk, .run(run_rtc),
      .half_period(8'h05), .wave(rtc));
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize;
      end
   end
   // ---
   // helpers
   // ---
   task automatic summarize;
      if (failures == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic cfg(int h, logic [2:0] m, logic [15:0] ld, logic en);
      tick(1);
      load_value[h*16+:16] = ld;
      if (h % 2) begin
         mode_b[h/2*3+:3] = m;
         enable_b[h/2] = en;
      end else begin
         mode_a[h/2*3+:3] = m;
         enable_a[h/2] = en;
      end
   endtask
   task automatic wait_to(int h, output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (timeout[h] !== 1'b1 && n < 200);
   endtask
   // ---
   // scenarios
   // ---
   task automatic t_period(int h, logic [15:0] ld, logic [7:0] pre);
      int n;
      prescale[h*8+:8] = pre;
      cfg(h, 3'h2, ld, 1);
      wait_to(h, n);
      wait_to(h, n);
      check("period", n, (ld + 1) * (pre + 1));
      cfg(h, 3'h0, ld, 0);
      prescale[h*8+:8] = 8'h00;
      tick(4);
   endtask
   task automatic t_oneshot;
      int n;
      cfg(0, 3'h1, 16'h0002, 1);
      wait_to(0, n);
      wait_to(0, n);
      check("shot_once", n, 200);
      check("shot_hold", count[15:0], 16'h0002);
      cfg(0, 3'h0, 16'h0009, 0);
   endtask
   task automatic t_stall;
      logic [15:0] v;
      stall_en[0] = 1;
      cfg(0, 3'h2, 16'h0009, 1);
      tick(3);
      cpu_halt = 1;
      tick(2);
      v = count[15:0];
      tick(4);
      check("stalled", count[15:0], v);
      stall_en[0] = 0;
      tick(3);
      check("unstalled", count[15:0] != v, 1);
      cpu_halt = 0;
      cfg(0, 3'h0, 16'h0003, 0);
   endtask
   task automatic t_pwm;
      int hi;
      cfg(0, 3'h5, 16'h0003, 1);
      for (int inv = 0; inv < 2; inv++) begin
         pwm_invert[0] = inv[0];
         tick(6);
         hi = 0;
         repeat (8) begin
            tick(1);
            hi += ccp_out[0];
         end
         check("pwm_oe", ccp_oe[0], 1);
         check("pwm_high", hi, inv ? 2 : 6);
      end
      cfg(0, 3'h0, 16'h0009, 0);
      pwm_invert[0] = 0;
   endtask
   task automatic t_edges;
      int ev, r, f, last;
      logic p;
      for (int m = 3; m < 5; m++)
         for (int e = 0; e < 3; e++) begin
            edge_a[1:0] = e[1:0];
            cfg(0, m[2:0], 16'h0009, 1);
            {ev, r, f, last, p} = 0;
            for (int i = 0; i < 48; i++) begin
               @(posedge ref_clk);
               run0 = i < 40;
               r += src0 && !p;
               f += !src0 && p;
               ev += capture_event[0];
               if ((e != 1 && src0 && !p) || (e != 0 && !src0 && p))
                  last = i;
               p = src0;
            end
            check("events", ev, e == 0 ? r : e == 1 ? f : r + f);
            // free count runs 9 down to 0 from the first clock edge after enable, not from an input edge
            if (m == 4)
               check("capture", capture[15:0], 9 - last % 10);
            if (m == 3 && e == 0)
               check("edge_count", count[15:0], 9 - r);
            cfg(0, 3'h0, 16'h0009, 0);
         end
   endtask
   task automatic t_join;
      int n;
      joined[0] = 1;
      enable_b[0] = 1;
      mode_b[2:0] = 3'h5;
      // rtc mode must stand while disabled so the count starts at zero
      cfg(0, 3'h6, 16'h0003, 0);
      load_value[31:16] = 16'h0000;
      cfg(0, 3'h6, 16'h0003, 1);
      run_rtc = 1;
      wait_to(0, n);
      // pulse follows the tick that found the match, count is one past
      check("rtc_count", count[31:0], 32'h00000004);
      check("half_oe", ccp_oe[1], 0);
      run_rtc = 0;
      cfg(0, 3'h0, 16'h0001, 0);
      load_value[31:16] = 16'h0001;
      cfg(0, 3'h2, 16'h0001, 1);
      for (n = 0; n < 8 && count[31:0] !== 32'h0000ffff; n++) tick(1);
      check("carry", count[31:0], 32'h0000ffff);
      check("carry_time", n, 2);
      mode_b[2:0] = 3'h0;
      enable_b[0] = 0;
      cfg(0, 3'h0, 16'h0001, 0);
      joined[0] = 0;
   endtask
   initial begin
      tick(5);
      rst_n = 1;
      t_period(0, 16'h0003, 8'h00);
      t_period(0, 16'h0001, 8'h01);
      t_period(3, 16'h0004, 8'h02);
      t_oneshot;
      t_stall;
      t_pwm;
      t_edges;
      t_join;
      summarize;
   end
endmodule // general_timer_module_tb_top
